// file: pkg/dbg_port_pkg.sv
// shared constants and carriers of the debug port register bank
// assumes one link clock; all users refer to names as dbg_port_pkg::name
package dbg_port_pkg;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [3:0] OFS_REVISION   = 4'h0;
    localparam logic [3:0] OFS_ERROR      = 4'h1;
    localparam logic [3:0] OFS_PHY_CTRL   = 4'h2;
    localparam logic [3:0] OFS_PHY_DIS    = 4'h3;
    localparam logic [3:0] OFS_KEY_FLAGS  = 4'h7;
    localparam logic [3:0] OFS_RESET_REQ  = 4'h8;
    localparam logic [3:0] OFS_CLK_SEL    = 4'h9;
    localparam logic [3:0] OFS_SYS_CTRL   = 4'ha;
    localparam logic [3:0] OFS_SYS_STATE  = 4'hb;
    localparam logic [3:0] OFS_CRC_STATE  = 4'hc;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int POS_IBD_EN      = 7;
    localparam int POS_PARITY_OFF  = 5;
    localparam int POS_TIMEOUT_OFF = 4;
    localparam int POS_RESP_OFF    = 3;
    localparam int POS_NACK_OFF    = 4;
    localparam int POS_CONT_OFF    = 3;
    localparam int POS_IF_DISABLE  = 2;
    localparam int POS_UROW_KEY    = 5;
    localparam int POS_PROG_KEY    = 4;
    localparam int POS_ERASE_KEY   = 3;
    localparam int POS_UROW_DONE   = 1;
    localparam int POS_CLK_REQ     = 0;

    // ------------------------------------------------------------------
    // values after reset, codes and counts
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_PHY_CTRL  = 8'h00;
    localparam logic [7:0] RST_PHY_DIS   = 8'h00;
    localparam logic [1:0] RST_CLK_SEL   = 2'h3;
    localparam logic [1:0] RST_SYS_CTRL  = 2'h1;
    localparam logic [7:0] RESET_CODE    = 8'h59;
    localparam logic [7:0] RUN_CODE      = 8'h00;
    localparam int TIMEOUT_LINK_CYCLES   = 65536;
    localparam int GUARD_MAX_CYCLES      = 128;
    localparam int IBD_IDLE_BITS         = 2;
    localparam int BIT_LINK_CYCLES       = 16;
    localparam int TIMER_W               = 17;

    typedef enum logic [2:0] {
        ERR_NONE     = 3'h0,
        ERR_PARITY   = 3'h1,
        ERR_FRAME    = 3'h2,
        ERR_TIMEOUT  = 3'h3,
        ERR_START    = 3'h4,
        ERR_RESERVED = 3'h5,
        ERR_BUS      = 3'h6,
        ERR_CONTEND  = 3'h7
    } err_code_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       req;
        logic       we;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dbg_access_t;

    typedef struct packed {
        logic parity;
        logic frame;
        logic start;
        logic bus;
    } phy_event_t;

endpackage : dbg_port_pkg

// file: rtl/cycle_timer.sv
// loadable down-counter giving a busy window and an expiry pulse
// assumes start and stop come from logic on the same clock
module cycle_timer #(
    parameter int W = 17
) (
    // clock, reset, enable
    input  wire logic         mclk_i,
    input  wire logic         sys_rst_i,
    input  wire logic         ce_i,
    // control
    input  wire logic         start_i,
    input  wire logic         stop_i,
    input  wire logic [W-1:0] load_i,
    // status
    output logic              busy_o,
    output logic              expire_o
);

    typedef struct packed {
        logic [W-1:0] count;
        logic         busy;
        logic         expire;
    } timer_state_t;

    timer_state_t st;
    timer_state_t next_st;

    always_comb begin
        next_st        = st;
        next_st.expire = 1'b0;
        if (start_i) begin
            next_st.count = load_i;
            next_st.busy  = (load_i != '0);
        end else if (stop_i) begin
            next_st.busy = 1'b0;
        end else if (st.busy) begin
            if (st.count == W'(1)) begin
                next_st.busy   = 1'b0;
                next_st.expire = 1'b1;
            end else begin
                next_st.count = st.count - W'(1);
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign busy_o   = st.busy;
    assign expire_o = st.expire;

endmodule : cycle_timer

// file: rtl/one_wire_debug_port_regs.sv
// control and status bank of the single-wire debug port
// assumes the link decoder presents register accesses on dbg_acc_i
// and the phy reports its events as one-cycle pulses on the link clock

// Overview of operation
// - bank reachable only by link instructions
// - read-only revision in bits 7:4
// - error code loaded on error, read clears
// - parity 1, stop bits 2, start 4
// - timeout 3, bus 6, contention 7
// - two idle bits between multibyte load bytes
// - parity disable ignores parity errors
// - timeout after 65536 cycles unless disabled
// - response signatures off when disabled
// - guard time 128 halving to 2 cycles
// - nack omitted on reset when disabled
// - contention detection while its bit is zero
// - disable bit resets interface and clock request
// - 0x59 asserts system reset, 0x00 releases
// - two-bit link clock select, default 3
// - key flags set on decode, prog clears
module one_wire_debug_port_regs #(
    parameter int         TIMEOUT_CYCLES = dbg_port_pkg::TIMEOUT_LINK_CYCLES,
    parameter int         BIT_CYCLES     = dbg_port_pkg::BIT_LINK_CYCLES,
    parameter logic [3:0] REVISION       = 4'h1 // arbitrary value
) (
    // clock, reset, enable
    input  wire logic                     mclk_i,
    input  wire logic                     sys_rst_i,
    input  wire logic                     ce_i,
    // register access from link decoder
    input  wire dbg_port_pkg::dbg_access_t dbg_acc_i,
    output logic                          dbg_ack_o,
    output logic [7:0]                    dbg_rdata_o,
    // cpu side
    input  wire logic                     cpu_rd_i,
    output logic                          cpu_ack_o,
    output logic [7:0]                    cpu_rdata_o,
    // phy events and link pin
    input  wire dbg_port_pkg::phy_event_t  phy_evt_i,
    input  wire logic                     pin_i,
    input  wire logic                     drive_en_i,
    input  wire logic                     drive_level_i,
    input  wire logic                     link_wake_i,
    // transfer sequencing
    input  wire logic                     rx_to_tx_i,
    input  wire logic                     tx_byte_done_i,
    input  wire logic                     multibyte_ld_i,
    input  wire logic                     acc_start_i,
    input  wire logic                     acc_resp_i,
    input  wire logic                     ldst_active_i,
    // key decoder and system
    input  wire logic                     key_urow_i,
    input  wire logic                     key_prog_i,
    input  wire logic                     key_erase_i,
    input  wire logic                     prog_start_i,
    input  wire logic [7:0]               sys_state_i,
    input  wire logic [2:0]               crc_state_i,
    // phy control and system outputs
    output logic                          phy_on_o,
    output logic                          clk_req_o,
    output logic [1:0]                    link_clk_sel_o,
    output logic                          resp_sig_en_o,
    output logic                          guard_busy_o,
    output logic                          ibd_hold_o,
    output logic                          nack_o,
    output logic                          sys_reset_o,
    output logic                          urow_done_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [2:0] err;
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [2:0] keys;
        logic [7:0] rst_req;
        logic [1:0] clk_sel;
        logic [1:0] sys_ctrl;
        logic       off;
        logic       sys_reset;
        logic       nack;
        logic       urow_done;
        logic       ack;
        logic [7:0] rdata;
        logic       cpu_ack;
        logic [7:0] cpu_rdata;
        logic [2:0] sync;
        logic       pin_level;
        logic [3:0] drv_dly;
        logic [3:0] drv_en_dly;
    } bank_state_t;

    bank_state_t st;
    bank_state_t next_st;

    logic                           guard_busy;
    logic                           ibd_busy;
    logic                           to_expire;
    logic                           guard_start;
    logic                           ibd_start;
    logic                           to_start;
    logic [dbg_port_pkg::TIMER_W-1:0] guard_load;
    logic                           wr;
    logic                           rd;
    logic                           contend;
    logic [2:0]                     err_evt;

    // ------------------------------------------------------------------
    // timers
    // ------------------------------------------------------------------
    always_comb begin
        // reserved guard code falls back to the longest guard
        if (st.ctrl_a[2:0] == 3'h7) begin
            guard_load = dbg_port_pkg::TIMER_W'(
                dbg_port_pkg::GUARD_MAX_CYCLES);
        end else begin
            guard_load = dbg_port_pkg::TIMER_W'(
                dbg_port_pkg::GUARD_MAX_CYCLES >> st.ctrl_a[2:0]);
        end
    end

    assign guard_start = rx_to_tx_i && !st.off;
    assign ibd_start   = tx_byte_done_i && multibyte_ld_i && !st.off
                      && st.ctrl_a[dbg_port_pkg::POS_IBD_EN];
    assign to_start    = acc_start_i && !st.off
                      && !st.ctrl_a[dbg_port_pkg::POS_TIMEOUT_OFF];

    cycle_timer #(.W(dbg_port_pkg::TIMER_W)) u_guard (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i     (ce_i),
        .start_i  (guard_start),
        .stop_i   (st.off),
        .load_i   (guard_load),
        .busy_o   (guard_busy),
        .expire_o ()
    );

    cycle_timer #(.W(dbg_port_pkg::TIMER_W)) u_inter_byte (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i     (ce_i),
        .start_i  (ibd_start),
        .stop_i   (st.off),
        .load_i   (dbg_port_pkg::TIMER_W'(
                   dbg_port_pkg::IBD_IDLE_BITS * BIT_CYCLES)),
        .busy_o   (ibd_busy),
        .expire_o ()
    );

    cycle_timer #(.W(dbg_port_pkg::TIMER_W)) u_timeout (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .ce_i     (ce_i),
        .start_i  (to_start),
        .stop_i   (acc_resp_i || st.off),
        .load_i   (dbg_port_pkg::TIMER_W'(TIMEOUT_CYCLES)),
        .busy_o   (),
        .expire_o (to_expire)
    );

    // ------------------------------------------------------------------
    // error capture
    // ------------------------------------------------------------------
    // drive delayed four: three sync stages plus the agreed level flop
    assign contend = st.drv_en_dly[3] && (st.pin_level != st.drv_dly[3])
                  && !st.ctrl_b[dbg_port_pkg::POS_CONT_OFF];

    always_comb begin
        // worst error wins when several land in one cycle
        err_evt = dbg_port_pkg::ERR_NONE;
        if (contend) begin
            err_evt = dbg_port_pkg::ERR_CONTEND;
        end else if (phy_evt_i.bus) begin
            err_evt = dbg_port_pkg::ERR_BUS;
        end else if (to_expire
                     && !st.ctrl_a[dbg_port_pkg::POS_TIMEOUT_OFF]) begin
            err_evt = dbg_port_pkg::ERR_TIMEOUT;
        end else if (phy_evt_i.start) begin
            err_evt = dbg_port_pkg::ERR_START;
        end else if (phy_evt_i.frame) begin
            err_evt = dbg_port_pkg::ERR_FRAME;
        end else if (phy_evt_i.parity
                     && !st.ctrl_a[dbg_port_pkg::POS_PARITY_OFF]) begin
            err_evt = dbg_port_pkg::ERR_PARITY;
        end
        if (st.off) begin
            err_evt = dbg_port_pkg::ERR_NONE;
        end
    end

    // ------------------------------------------------------------------
    // register bank
    // ------------------------------------------------------------------
    assign wr = dbg_acc_i.req && dbg_acc_i.we && !st.off;
    assign rd = dbg_acc_i.req && !dbg_acc_i.we && !st.off;

    always_comb begin
        next_st           = st;
        next_st.ack       = dbg_acc_i.req;
        next_st.cpu_ack   = cpu_rd_i;
        next_st.cpu_rdata = 8'h00;
        next_st.nack      = 1'b0;
        next_st.urow_done = 1'b0;
        next_st.sync      = {st.sync[1:0], pin_i};
        if (st.sync[2] == st.sync[1]) begin
            next_st.pin_level = st.sync[2];
        end
        next_st.drv_dly    = {st.drv_dly[2:0], drive_level_i};
        next_st.drv_en_dly = {st.drv_en_dly[2:0], drive_en_i};

        // read answer; unmapped and reserved offsets read zero
        next_st.rdata = 8'h00;
        if (rd) begin
            unique case (dbg_acc_i.addr)
                dbg_port_pkg::OFS_REVISION:
                    next_st.rdata = {REVISION, 4'h0};
                dbg_port_pkg::OFS_ERROR:
                    next_st.rdata = {5'h00, st.err};
                dbg_port_pkg::OFS_PHY_CTRL:
                    next_st.rdata = st.ctrl_a & 8'hbf;
                dbg_port_pkg::OFS_PHY_DIS:
                    next_st.rdata = st.ctrl_b & 8'h1c;
                dbg_port_pkg::OFS_KEY_FLAGS:
                    next_st.rdata = {2'h0, st.keys, 3'h0};
                dbg_port_pkg::OFS_RESET_REQ:
                    next_st.rdata = st.rst_req;
                dbg_port_pkg::OFS_CLK_SEL:
                    next_st.rdata = {6'h00, st.clk_sel};
                dbg_port_pkg::OFS_SYS_CTRL:
                    next_st.rdata = {6'h00, st.sys_ctrl};
                dbg_port_pkg::OFS_SYS_STATE:
                    next_st.rdata = sys_state_i & 8'h7d;
                dbg_port_pkg::OFS_CRC_STATE:
                    next_st.rdata = {5'h00, crc_state_i};
                default:
                    next_st.rdata = 8'h00;
            endcase
        end

        // error field: a fresh error beats the read clear
        if (rd && dbg_acc_i.addr == dbg_port_pkg::OFS_ERROR) begin
            next_st.err = dbg_port_pkg::ERR_NONE;
        end
        if (err_evt != dbg_port_pkg::ERR_NONE) begin
            next_st.err = err_evt;
        end

        if (wr) begin
            unique case (dbg_acc_i.addr)
                dbg_port_pkg::OFS_PHY_CTRL:
                    next_st.ctrl_a = dbg_acc_i.wdata & 8'hbf;
                dbg_port_pkg::OFS_PHY_DIS:
                    next_st.ctrl_b = dbg_acc_i.wdata & 8'h1c;
                dbg_port_pkg::OFS_KEY_FLAGS:
                    next_st.keys[2] =
                        dbg_acc_i.wdata[dbg_port_pkg::POS_UROW_KEY];
                dbg_port_pkg::OFS_RESET_REQ:
                    next_st.rst_req = dbg_acc_i.wdata;
                dbg_port_pkg::OFS_CLK_SEL:
                    next_st.clk_sel = dbg_acc_i.wdata[1:0];
                dbg_port_pkg::OFS_SYS_CTRL: begin
                    next_st.sys_ctrl[dbg_port_pkg::POS_CLK_REQ] =
                        dbg_acc_i.wdata[dbg_port_pkg::POS_CLK_REQ];
                    // done bit only takes effect with the row key held
                    if (st.keys[2]) begin
                        next_st.sys_ctrl[dbg_port_pkg::POS_UROW_DONE] =
                            dbg_acc_i.wdata[dbg_port_pkg::POS_UROW_DONE];
                        next_st.urow_done =
                            dbg_acc_i.wdata[dbg_port_pkg::POS_UROW_DONE];
                    end
                end
                default: begin
                end
            endcase
        end

        // key flags: clears first so a decode in the same cycle wins
        if (wr && dbg_acc_i.addr == dbg_port_pkg::OFS_RESET_REQ
            && dbg_acc_i.wdata == dbg_port_pkg::RESET_CODE) begin
            next_st.keys[0] = 1'b0;
        end
        if (prog_start_i) begin
            next_st.keys[1] = 1'b0;
        end
        if (!st.off) begin
            next_st.keys = next_st.keys
                         | {key_urow_i, key_prog_i, key_erase_i};
        end

        // system reset held while the request code stands
        next_st.sys_reset = (next_st.rst_req == dbg_port_pkg::RESET_CODE);
        if (next_st.sys_reset && !st.sys_reset && ldst_active_i
            && !st.ctrl_b[dbg_port_pkg::POS_NACK_OFF]) begin
            next_st.nack = 1'b1;
        end

        // disable clears the whole phy setup and keys until woken
        if (wr && dbg_acc_i.addr == dbg_port_pkg::OFS_PHY_DIS
            && dbg_acc_i.wdata[dbg_port_pkg::POS_IF_DISABLE]) begin
            next_st.off      = 1'b1;
            next_st.ctrl_a   = dbg_port_pkg::RST_PHY_CTRL;
            next_st.ctrl_b   = dbg_port_pkg::RST_PHY_DIS;
            next_st.keys     = 3'h0;
            next_st.err      = dbg_port_pkg::ERR_NONE;
            next_st.clk_sel  = dbg_port_pkg::RST_CLK_SEL;
            next_st.sys_ctrl = 2'h0;
        end else if (st.off && link_wake_i) begin
            next_st.off      = 1'b0;
            // clock request is on by default once enabled again
            next_st.sys_ctrl = dbg_port_pkg::RST_SYS_CTRL;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st          <= '0;
            st.ctrl_a   <= dbg_port_pkg::RST_PHY_CTRL;
            st.ctrl_b   <= dbg_port_pkg::RST_PHY_DIS;
            st.rst_req  <= dbg_port_pkg::RUN_CODE;
            st.clk_sel  <= dbg_port_pkg::RST_CLK_SEL;
            st.sys_ctrl <= dbg_port_pkg::RST_SYS_CTRL;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign dbg_ack_o      = st.ack;
    assign dbg_rdata_o    = st.rdata;
    assign cpu_ack_o      = st.cpu_ack;
    assign cpu_rdata_o    = st.cpu_rdata;
    assign phy_on_o       = !st.off;
    assign clk_req_o      = st.sys_ctrl[dbg_port_pkg::POS_CLK_REQ];
    assign link_clk_sel_o = st.clk_sel;
    assign resp_sig_en_o  = !st.ctrl_a[dbg_port_pkg::POS_RESP_OFF];
    assign guard_busy_o   = guard_busy;
    assign ibd_hold_o     = ibd_busy;
    assign nack_o         = st.nack;
    assign sys_reset_o    = st.sys_reset;
    assign urow_done_o    = st.urow_done;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i || !ce_i);

    AST_CPU_ZERO: assert property (
        cpu_rd_i |=> cpu_ack_o && cpu_rdata_o == 8'h00)
        else $error("cpu read returned data");
    AST_REV_READ: assert property (
        rd && dbg_acc_i.addr == dbg_port_pkg::OFS_REVISION
        |=> dbg_rdata_o == {REVISION, 4'h0})
        else $error("revision read wrong");
    AST_ERR_CLEAR: assert property (
        rd && dbg_acc_i.addr == dbg_port_pkg::OFS_ERROR
        && err_evt == dbg_port_pkg::ERR_NONE
        |=> st.err == 3'h0 && dbg_rdata_o == {5'h00, $past(st.err)})
        else $error("error field not cleared on read");
    AST_PARITY_CODE: assert property (
        phy_evt_i.parity && !st.off && !contend && !phy_evt_i.bus
        && !phy_evt_i.start && !phy_evt_i.frame && !to_expire
        && !st.ctrl_a[dbg_port_pkg::POS_PARITY_OFF]
        |=> st.err == 3'h1)
        else $error("parity error not coded as one");
    AST_PARITY_OFF: assert property (
        st.ctrl_a[dbg_port_pkg::POS_PARITY_OFF] && phy_evt_i == 4'h8
        && !contend && !to_expire |-> err_evt == dbg_port_pkg::ERR_NONE)
        else $error("parity error raised while disabled");
    AST_CONTEND: assert property (
        contend && !st.off |=> st.err == 3'h7)
        else $error("contention not coded as seven");
    AST_NO_CONTEND: assert property (
        st.ctrl_b[dbg_port_pkg::POS_CONT_OFF] && st.err != 3'h7
        |=> st.err != 3'h7)
        else $error("contention detected while disabled");
    AST_GUARD_TWO: assert property (
        guard_start && st.ctrl_a[2:0] == 3'h6 ##1 !guard_start[*2]
        |-> guard_busy_o ##1 !guard_busy_o)
        else $error("shortest guard time is not two cycles");
    AST_RESET_REQ: assert property (
        wr && dbg_acc_i.addr == dbg_port_pkg::OFS_RESET_REQ
        |=> sys_reset_o == ($past(dbg_acc_i.wdata) == 8'h59))
        else $error("system reset does not follow request");
    AST_DISABLE: assert property (
        wr && dbg_acc_i.addr == dbg_port_pkg::OFS_PHY_DIS
        && dbg_acc_i.wdata[dbg_port_pkg::POS_IF_DISABLE]
        |=> !phy_on_o && st.keys == 3'h0 && st.ctrl_a == 8'h00
        && link_clk_sel_o == 2'h3 && !clk_req_o)
        else $error("disable did not reset the interface");
    AST_PROG_CLEAR: assert property (
        prog_start_i && !key_prog_i |=> !st.keys[1])
        else $error("programming key flag not cleared");

    COV_ERR_READ: cover property (
        st.err != 3'h0 ##1 rd && dbg_acc_i.addr == dbg_port_pkg::OFS_ERROR);
    COV_RESET_CYCLE: cover property (
        sys_reset_o ##[1:20] !sys_reset_o);
    COV_IBD: cover property (ibd_start ##1 ibd_hold_o);

endmodule : one_wire_debug_port_regs

// file: testbench/link_host_model.sv
// debugger side of the register port, one access per call
// assumes calls begin two ns after a rising edge of mclk_i
module link_host_model (
    // link clock and answer
    input  wire logic                 mclk_i,
    input  wire logic                 dbg_ack_i,
    input  wire logic [7:0]           dbg_rdata_i,
    // request
    output dbg_port_pkg::dbg_access_t dbg_acc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial dbg_acc_o = '0;
    task automatic access(input logic we, input logic [3:0] a,
                          input logic [7:0] d, output logic [7:0] q);
        dbg_acc_o = '{1'b1, we, a, d};
        @(posedge mclk_i);
        // never waits for the ack; samples it one edge later, signatures on or off
        #1 q = dbg_ack_i ? dbg_rdata_i : 8'hxx;
        // idle fields inverted so stale values never look valid
        #1 dbg_acc_o = '{1'b0, ~we, ~a, ~d};
        @(posedge mclk_i);
        #2;
    endtask : access
endmodule : link_host_model

// file: testbench/one_wire_debug_port_regs_tb.sv
// self-checking bench for the debug port register bank
// assumes the package and the host model are compiled first
module one_wire_debug_port_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk_i = 0, sys_rst_i = 1, ack, cpu_ack, on, rs_en;
    logic       g_busy, ibd, srst, creq, nack, udone;
    logic [1:0] csel;
    logic [7:0] q, rd, cpu_q;
    logic [18:0] ev = '0;
    logic [1:0] seen = '0;
    int         failures = 0, checks_done = 0, n;
    dbg_port_pkg::dbg_access_t acc;
    // we, offset, write data, expected read
    logic [23:0] rows [17] = '{24'h0_0_00_10, 24'h0_1_00_00, 24'h0_2_00_00,
        24'h0_3_00_00, 24'h0_7_00_00, 24'h0_9_00_03, 24'h0_a_00_01,
        24'h0_b_00_7d, 24'h0_c_00_04, 24'h1_0_ff_10, 24'h1_1_ff_00,
        24'h1_2_be_be, 24'h1_3_18_18, 24'h1_4_ff_00, 24'h1_6_ff_00,
        24'h1_9_01_01, 24'h1_d_ff_00};
    logic [7:0] errs [4] = '{8'h06, 8'h04, 8'h02, 8'h01};
    one_wire_debug_port_regs #(.TIMEOUT_CYCLES(40), .BIT_CYCLES(4)) i_dut (
        .mclk_i, .sys_rst_i, .ce_i(1'b1), .dbg_acc_i(acc), .dbg_ack_o(ack),
        .dbg_rdata_o(rd), .cpu_rd_i(ev[17]), .cpu_ack_o(cpu_ack),
        .cpu_rdata_o(cpu_q), .phy_evt_i(ev[3:0]), .pin_i(ev[18]),
        .drive_en_i(ev[5]), .drive_level_i(ev[4]), .link_wake_i(ev[16]),
        .rx_to_tx_i(ev[6]), .tx_byte_done_i(ev[7]), .multibyte_ld_i(ev[8]),
        .acc_start_i(ev[9]), .acc_resp_i(ev[10]), .ldst_active_i(ev[11]),
        .key_urow_i(ev[12]), .key_prog_i(ev[13]), .key_erase_i(ev[14]),
        .prog_start_i(ev[15]), .sys_state_i(8'hff), .crc_state_i(3'h4),
        .phy_on_o(on), .clk_req_o(creq), .link_clk_sel_o(csel),
        .resp_sig_en_o(rs_en), .guard_busy_o(g_busy), .ibd_hold_o(ibd),
        .nack_o(nack), .sys_reset_o(srst), .urow_done_o(udone));
    link_host_model i_host (.mclk_i, .dbg_ack_i(ack), .dbg_rdata_i(rd),
        .dbg_acc_o(acc));
    // one-cycle pulses latched so checks may come later
    always @(posedge mclk_i) seen <= seen | {nack, udone};
    task automatic chk(input string s, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", s, exp, seen);
        end
    endtask : chk
    // extra edge lets a loaded error code land before the next read
    task automatic pulse(input int b);
        ev[b] = 1'b1;
        @(posedge mclk_i);
        #2 ev[b] = 1'b0;
        @(posedge mclk_i);
        #2;
    endtask : pulse
    task automatic meas(input int b, input logic sel);
        ev[b] = 1'b1;
        @(posedge mclk_i);
        #2 ev[b] = 1'b0;
        n = 0;
        repeat (300) begin
            n += sel ? ibd : g_busy;
            @(posedge mclk_i);
            #2;
        end
    endtask : meas
    task automatic rd_chk(input string s, input logic [3:0] a,
                          input logic [7:0] e);
        i_host.access(1'b0, a, 8'h00, q);
        chk(s, q, e);
    endtask : rd_chk
    // pin held low against a driven high for six cycles
    task automatic clash(input logic [7:0] e);
        ev[5:4] = 2'h3;
        #120 ev[5:4] = 2'h0;
        #80 rd_chk("clash", 4'h1, e);
    endtask : clash
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial forever #10 mclk_i = ~mclk_i;
    initial begin
        #100000 failures++;
        tally_and_finish;
    end
    initial begin
        repeat (16) @(posedge mclk_i);
        #2 sys_rst_i = 0;
        foreach (rows[i]) begin
            if (rows[i][20]) i_host.access(1'b1, rows[i][19:16],
                rows[i][15:8], q);
            rd_chk("reg", rows[i][19:16], rows[i][7:0]);
        end
        clash(8'h00);
        chk("rsp", rs_en, 0);
        chk("sel", csel, 1);
        meas(6, 0);
        chk("guard", 8'(n), 8'h02);
        ev[8] = 1'b1;
        meas(7, 1);
        chk("ibd", 8'(n), 8'h08);
        pulse(3);
        rd_chk("par_off", 4'h1, 0);
        pulse(9);
        #1200;
        rd_chk("to_off", 4'h1, 0);
        i_host.access(1'b1, 4'h2, 8'h00, q);
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            rd_chk("err", 4'h1, errs[b]);
            rd_chk("clr", 4'h1, 0);
        end
        pulse(9);
        #1200;
        rd_chk("tmo", 4'h1, 3);
        ev[11] = 1'b1;
        i_host.access(1'b1, 4'h8, 8'h59, q);
        chk("srst", srst, 1);
        i_host.access(1'b1, 4'h8, 8'h00, q);
        chk("run", srst, 0);
        chk("nack_off", {7'h00, seen[1]}, 8'h00);
        i_host.access(1'b1, 4'h3, 8'h08, q);
        i_host.access(1'b1, 4'h8, 8'h59, q);
        i_host.access(1'b1, 4'h8, 8'h00, q);
        chk("nack", {7'h00, seen[1]}, 8'h01);
        ev[11] = 1'b0;
        pulse(13);
        rd_chk("key", 4'h7, 8'h10);
        pulse(15);
        rd_chk("prog", 4'h7, 0);
        pulse(12);
        rd_chk("urow", 4'h7, 8'h20);
        i_host.access(1'b1, 4'ha, 8'h03, q);
        chk("udone", {7'h00, seen[0]}, 8'h01);
        ev[17] = 1'b1;
        @(posedge mclk_i);
        #1 chk("cpu", cpu_q, 8'h00);
        chk("cpu_ack", {7'h00, cpu_ack}, 8'h01);
        #1 ev[17] = 1'b0;
        i_host.access(1'b1, 4'h3, 8'h04, q);
        chk("on", on, 0);
        chk("creq", {7'h00, creq}, 8'h00);
        i_host.access(1'b1, 4'h2, 8'hff, q);
        pulse(16);
        rd_chk("dis", 4'h2, 0);
        chk("dis_sel", {6'h00, csel}, 8'h03);
        clash(8'h07);
        i_host.access(1'b1, 4'h9, 8'h00, q);
        sys_rst_i = 1;
        #40 sys_rst_i = 0;
        chk("rst", {4'h0, creq, on, csel}, 8'h0f);
        tally_and_finish;
    end
endmodule : one_wire_debug_port_regs_tb
